// File: design/pic_core.sv
// Core-level external interrupt controller: registers, gateways, priority tree.
// Assumes a register master with one-cycle strobes and a single machine-mode hart.
`timescale 1ns/10ps
// Behaviour
// - Up to 255 sources, each individually enabled
// - Fifteen programmable priority levels per source
// - Optional reversed ordering as seen by firmware
// - Threshold suppresses priorities not above it
// - Wake-up when winner has top priority
// - Single target: machine mode of hart
// - Per-source gateway gives synchronised active-high level
// - One outstanding request per source, merged
// - Plain level gateways only synchronise, stateless
// - Configurable gateway: edge/level and polarity
// - Edge sets sticky pending flop, drives request
// - Highest priority wins, lowest ID on ties
// - Notify only above threshold and current level
// - Winning source ID readable in status
// - Tree is combinational; one stage after it holds ID and priority together
// - Reverse mode inverts priority registers both ways
// - Handler address: base, claimed ID, two zeros
// - Capture write snapshots winner ID and priority
module pic_core
    import pic_pkg::*;
#(
    parameter int NUM_SRC = 255,
    parameter int NUM_CFG_GW = 8
) (
    input wire logic core_clk,              // Core clock, 50 MHz
    input wire logic resetn,                // Async reset, active low
    input wire logic [ADDR_W-1:0] addr,     // Register byte address
    input wire logic [31:0] wdata,          // Write data
    input wire logic wr_en,                 // Write strobe
    input wire logic rd_en,                 // Read strobe
    output logic [31:0] rdata,              // Read data, cycle after strobe
    input wire logic [NUM_SRC:1] ext_src,   // Asynchronous source requests
    output logic ext_int,                   // Machine external interrupt
    output logic wakeup,                    // Wake-up toward the hart
    output logic [ID_W-1:0] win_id          // Current winning source ID
);
    // Refused at elaboration: the tree has one leaf per 8-bit ID
    if (NUM_SRC < 1 || NUM_SRC > LEAVES - 1) begin : g_bad_src
        $error("NUM_SRC must be 1..255");
    end
    if (NUM_CFG_GW < 0 || NUM_CFG_GW > NUM_SRC) begin : g_bad_cfg
        $error("NUM_CFG_GW must be 0..NUM_SRC");
    end
    if ((1 << ID_W) != LEAVES) begin : g_bad_leaves
        $error("LEAVES must equal 2**ID_W");
    end

    // Firmware-visible priority values are inverted in reverse mode
    function automatic logic [PRI_W-1:0] fw_order(input logic [PRI_W-1:0] v, input logic rev);
        return rev ? ~v : v;
    endfunction : fw_order

    logic rev_r;
    logic [PRI_W-1:0] thr_r;
    logic [PRI_W-1:0] cur_r;
    logic [PRI_W-1:0] clid_r;
    logic [BASE_W-1:0] base_r;
    logic [ID_W-1:0] claim_id_r;
    logic [PRI_W-1:0] pri_r [0:LEAVES-1];
    logic [LEAVES-1:0] en_r;
    gw_cfg_t gw_cfg_r [0:LEAVES-1];
    logic [31:0] rdata_r;
    logic ext_int_r;
    logic wake_r;
    win_t win_r;

    // Register map, byte addresses; index s is the source number:
    //   0x000 ordering, 0x004 threshold, 0x008 current level,
    //   0x00C claimed priority, 0x010 vector base, 0x014 capture,
    //   0x018 handler address, 0x01C status,
    //   0x400 + 4*s priority, 0x800 + 4*s enable,
    //   0xC00 + 4*s gateway control, 0x1000 + 4*s pending clear.
    // Index 0 and sources beyond NUM_SRC are refused: writes are
    // dropped and reads return zero, so a mistyped index cannot
    // alias a live source.
    // Address decode
    wire [2:0] region = addr[12:10];
    wire [ID_W-1:0] idx = addr[9:2];
    wire idx_ok = (idx != ID_NONE) && (32'(idx) <= NUM_SRC);
    wire wr_glob = wr_en && (region == REGION_GLOBAL) && (addr[1:0] == 2'h0);
    wire wr_cfg = wr_glob && (idx == OFS_CONFIG);
    wire wr_thr = wr_glob && (idx == OFS_THRESH);
    wire wr_cur = wr_glob && (idx == OFS_CURLVL);
    wire wr_clid = wr_glob && (idx == OFS_CLAIMPRI);
    wire wr_base = wr_glob && (idx == OFS_VECBASE);
    wire wr_cap = wr_glob && (idx == OFS_CAPTURE);
    wire wr_prio = wr_en && (region == REGION_PRIO) && idx_ok;
    wire wr_ena = wr_en && (region == REGION_ENABLE) && idx_ok;
    wire wr_gwc = wr_en && (region == REGION_GWCTRL) && idx_ok;
    wire wr_gwclr = wr_en && (region == REGION_GWCLR) && idx_ok;
    wire [PRI_W-1:0] wpri = fw_order(wdata[PRI_W-1:0], rev_r);

    // Global registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rev_r <= 1'b0;
            thr_r <= PRI_RST;
            cur_r <= PRI_RST;
            clid_r <= PRI_RST;
            base_r <= BASE_RST;
            claim_id_r <= ID_NONE;
        end else begin
            if (wr_cfg) begin
                rev_r <= wdata[CFG_REV_BIT];
            end
            if (wr_thr) begin
                thr_r <= wpri;
            end
            if (wr_cur) begin
                cur_r <= wpri;
            end
            if (wr_base) begin
                base_r <= wdata[31:VECBASE_LSB];
            end
            // Snapshot ignores thresholds and the hart's enable
            if (wr_cap) begin
                claim_id_r <= win_r.id;
                clid_r <= win_r.pri;
            end else if (wr_clid) begin
                clid_r <= wpri;
            end
        end
    end

    // Per-source priority, enable and gateway configuration
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            en_r <= '0;
            for (int k = 0; k < LEAVES; k++) begin
                pri_r[k] <= PRI_RST;
                gw_cfg_r[k] <= GW_CFG_RST;
            end
        end else begin
            if (wr_prio) begin
                pri_r[idx] <= wpri;
            end
            if (wr_ena) begin
                en_r[idx] <= wdata[0];
            end
            if (wr_gwc) begin
                gw_cfg_r[idx] <= '{edge_mode: wdata[GW_EDGE_BIT], polarity: wdata[GW_POL_BIT]};
            end
        end
    end

    // Gateways: the first NUM_CFG_GW sources are configurable
    // The rest only synchronise; they cost two flops each, which is
    // why the configurable count is kept separate.
    logic [LEAVES-1:0] req_w;
    logic [LEAVES-1:0] pend_w;
    assign req_w[0] = 1'b0;
    assign pend_w[0] = 1'b0;

    generate
        for (genvar s = 1; s < LEAVES; s++) begin : g_src
            if (s <= NUM_SRC) begin : g_used
                pic_gateway #(
                    .CONFIGURABLE(s <= NUM_CFG_GW)
                ) u_gw (
                    .core_clk(core_clk),
                    .resetn(resetn),
                    .src_async(ext_src[s]),
                    .cfg(gw_cfg_r[s]),
                    .clear(wr_gwclr && (idx == ID_W'(s))),
                    .req(req_w[s]),
                    .pend(pend_w[s])
                );
            end else begin : g_unused
                assign req_w[s] = 1'b0;
                assign pend_w[s] = 1'b0;
            end
        end
    endgenerate

    // Priority tree in heap order; leaf j sits at node LEAVES-1+j.
    // Fully combinational; no stage inside, so ID and priority need
    // no extra alignment before win_r.
    // A single request bit per source means repeats merge into one entry.
    logic [PRI_W-1:0] tp [0:2*LEAVES-2];
    logic [ID_W-1:0] ti [0:2*LEAVES-2];

    generate
        for (genvar j = 0; j < LEAVES; j++) begin : g_leaf
            assign tp[LEAVES-1+j] = (req_w[j] && en_r[j]) ? pri_r[j] : PRI_RST;
            assign ti[LEAVES-1+j] = ID_W'(j);
        end
        for (genvar n = 0; n < LEAVES - 1; n++) begin : g_node
            // Left child always holds the lower IDs, so it wins ties
            wire take_right = tp[2*n+2] > tp[2*n+1];
            assign tp[n] = take_right ? tp[2*n+2] : tp[2*n+1];
            assign ti[n] = take_right ? ti[2*n+2] : ti[2*n+1];
        end
    endgenerate

    // One stage after the tree: a level source seen at the pins is
    // in win_r three edges later and on ext_int one edge after that.
    // Winner is staged as one struct, so ID and priority stay aligned
    wire win_t tree_win = '{id: (tp[0] == PRI_RST) ? ID_NONE : ti[0], pri: tp[0]};
    wire notify_nxt = (win_r.pri > thr_r) && (win_r.pri > cur_r);
    wire wake_nxt = (win_r.pri == PRI_TOP);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            win_r <= '{id: ID_NONE, pri: PRI_RST};
            ext_int_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            win_r <= tree_win;
            ext_int_r <= notify_nxt;
            wake_r <= wake_nxt;
        end
    end

    // Read path
    // Priority-type fields leave through fw_order so that firmware
    // sees one ordering on both write and read.
    wire [31:0] handler_addr = {base_r, claim_id_r, 2'b00};
    wire [31:0] rd_glob =
        (idx == OFS_CONFIG) ? 32'(rev_r) :
        (idx == OFS_THRESH) ? 32'(fw_order(thr_r, rev_r)) :
        (idx == OFS_CURLVL) ? 32'(fw_order(cur_r, rev_r)) :
        (idx == OFS_CLAIMPRI) ? 32'(fw_order(clid_r, rev_r)) :
        (idx == OFS_VECBASE) ? {base_r, 10'h000} :
        (idx == OFS_HANDLER) ? handler_addr :
        (idx == OFS_STATUS) ? {ext_int_r, wake_r, 14'h0000, win_r.id,
                               4'h0, fw_order(win_r.pri, rev_r)} :
        32'h00000000;
    wire [31:0] rdata_nxt =
        (addr[1:0] != 2'h0) ? 32'h00000000 :
        (region == REGION_GLOBAL) ? rd_glob :
        (region == REGION_PRIO && idx_ok) ? 32'(fw_order(pri_r[idx], rev_r)) :
        (region == REGION_ENABLE && idx_ok) ? 32'(en_r[idx]) :
        (region == REGION_GWCTRL && idx_ok) ? 32'({gw_cfg_r[idx].edge_mode,
                                                    gw_cfg_r[idx].polarity}) :
        (region == REGION_GWCLR && idx_ok) ? 32'(pend_w[idx]) :
        32'h00000000;

    // Read data stand one cycle only; zero otherwise, so a stale word
    // is never taken for an answer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 32'h00000000;
        end else if (rd_en) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= 32'h00000000;
        end
    end

    assign rdata = rdata_r;
    assign ext_int = ext_int_r;
    assign wakeup = wake_r;
    assign win_id = win_r.id;

    // Checks below all run on the core clock and rest during reset
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    a_notify_strict: assert property (
        ext_int_r |-> ($past(win_r.pri) > $past(thr_r)) && ($past(win_r.pri) > $past(cur_r)))
        else $error("notification without strict priority excess");
    a_zero_silent: assert property (
        win_r.pri == PRI_RST |=> !ext_int_r)
        else $error("priority zero raised a notification");
    a_wake_top: assert property (
        win_r.pri == PRI_TOP |=> wakeup)
        else $error("top priority winner did not wake the hart");
    a_wake_only_top: assert property (
        win_r.pri != PRI_TOP |=> !wakeup)
        else $error("wake-up without top priority");
    a_capture_snap: assert property (
        wr_cap |=> claim_id_r == $past(win_r.id) && clid_r == $past(win_r.pri))
        else $error("capture did not snapshot the winner");
    a_win_valid: assert property (
        tree_win.id != ID_NONE |-> req_w[tree_win.id] && en_r[tree_win.id]
                                   && tree_win.pri == pri_r[tree_win.id])
        else $error("winner not a pending enabled source at its priority");
    a_thr_reverse: assert property (
        wr_thr && rev_r |=> thr_r == ~$past(wdata[PRI_W-1:0]))
        else $error("reverse mode threshold not inverted on write");
    a_hap_layout: assert property (
        rd_en && region == REGION_GLOBAL && idx == OFS_HANDLER && addr[1:0] == 2'h0
        |=> rdata == {$past(base_r), $past(claim_id_r), 2'b00})
        else $error("handler address read has wrong layout");
    a_reset_quiet: assert property (
        $rose(resetn) |-> !ext_int && !wakeup)
        else $error("outputs not cleared by reset");
    // Register stores: each write lands at the edge it is sampled
    a_rev_store: assert property (
        wr_cfg |=> rev_r == $past(wdata[CFG_REV_BIT]))
        else $error("ordering bit not stored");
    a_thr_normal: assert property (
        wr_thr && !rev_r |=> thr_r == $past(wdata[PRI_W-1:0]))
        else $error("normal mode threshold altered on write");
    a_cur_store: assert property (
        wr_cur |=> cur_r == fw_order($past(wdata[PRI_W-1:0]), $past(rev_r)))
        else $error("current level not stored in internal order");
    a_clid_store: assert property (
        wr_clid |=> clid_r == fw_order($past(wdata[PRI_W-1:0]), $past(rev_r)))
        else $error("claimed priority not stored in internal order");
    a_prio_store: assert property (
        wr_prio |=> pri_r[$past(idx)] == fw_order($past(wdata[PRI_W-1:0]), $past(rev_r)))
        else $error("source priority not stored");
    a_enable_store: assert property (
        wr_ena |=> en_r[$past(idx)] == $past(wdata[0]))
        else $error("source enable not stored");
    a_gwcfg_store: assert property (
        wr_gwc |=> gw_cfg_r[$past(idx)] == {$past(wdata[GW_EDGE_BIT]),
                                            $past(wdata[GW_POL_BIT])})
        else $error("gateway type or polarity not stored");
    a_base_store: assert property (
        wr_base |=> base_r == $past(wdata[31:VECBASE_LSB]))
        else $error("vector base not stored");
    a_notify_due: assert property (
        win_r.pri > thr_r && win_r.pri > cur_r |=> ext_int_r)
        else $error("notification missing for an eligible winner");
    a_stat_id: assert property (
        rd_en && region == REGION_GLOBAL && idx == OFS_STATUS && addr[1:0] == 2'h0
        |=> rdata[15:8] == $past(win_r.id))
        else $error("status read does not show the winning source");
    a_id_range: assert property (
        win_r.id <= ID_W'(NUM_SRC))
        else $error("winning source beyond the source count");

    // Scenarios the bench is expected to reach
    c_notify: cover property (!ext_int_r ##1 ext_int_r);
    c_wake: cover property (wakeup && ext_int);
    c_capture: cover property (wr_cap && win_r.id != ID_NONE);
    c_reverse: cover property (rev_r && ext_int_r);
endmodule : pic_core

// File: design/pic_gateway.sv
// Per-source gateway: synchronises one asynchronous request into the core clock.
// Assumes the source holds a request for at least two core clock cycles.
`timescale 1ns/10ps
module pic_gateway
    import pic_pkg::*;
#(
    parameter bit CONFIGURABLE = 1'b1
) (
    input wire logic core_clk,     // Core clock
    input wire logic resetn,       // Async reset, active low
    input wire logic src_async,    // Raw request from the source
    input wire gw_cfg_t cfg,       // Type and polarity
    input wire logic clear,        // One-cycle pending clear
    output logic req,              // Level request, active high
    output logic pend              // Sticky pending flop state
);
    logic sync1_r;
    logic sync2_r;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= src_async;
            sync2_r <= sync1_r;
        end
    end

    generate
        if (CONFIGURABLE) begin : g_cfg
            logic prev_r;
            logic sticky_pending_flop_r;
            wire active = sync2_r ^ cfg.polarity;
            wire prev_active = prev_r ^ cfg.polarity;
            wire edge_hit = cfg.edge_mode && active && !prev_active;

            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    prev_r <= 1'b0;
                    sticky_pending_flop_r <= 1'b0;
                end else begin
                    prev_r <= sync2_r;
                    // Set wins over a clear in the same cycle
                    if (edge_hit) begin
                        sticky_pending_flop_r <= 1'b1;
                    end else if (clear) begin
                        sticky_pending_flop_r <= 1'b0;
                    end
                end
            end

            assign req = cfg.edge_mode ? sticky_pending_flop_r : active;
            assign pend = sticky_pending_flop_r;

            default clocking cb @(posedge core_clk);
            endclocking
            default disable iff (!resetn);

            a_edge_sticky_hold: assert property (
                sticky_pending_flop_r && !clear |=> sticky_pending_flop_r)
                else $error("edge pending flop dropped without clear");
            a_level_follow_sync: assert property (
                !cfg.edge_mode && $stable(cfg) |-> req == (sync2_r ^ cfg.polarity))
                else $error("level request does not follow synchronised input");
            c_edge_capture: cover property (edge_hit ##1 sticky_pending_flop_r);
        end else begin : g_plain
            // Plain on-chip level source: synchroniser only, no state
            assign req = sync2_r;
            assign pend = 1'b0;
        end
    endgenerate
endmodule : pic_gateway

// File: design/pic_pkg.sv
// Shared constants and types for the core-level external interrupt controller.
// Assumes one core clock domain and a simple strobe register port.
package pic_pkg;
    localparam int ADDR_W = 13;
    localparam int PRI_W = 4;
    localparam int ID_W = 8;
    localparam int BASE_W = 22;
    localparam int LEAVES = 256;

    // Register regions, selected by byte address bits [12:10]
    localparam logic [2:0] REGION_GLOBAL = 3'h0;
    localparam logic [2:0] REGION_PRIO = 3'h1;
    localparam logic [2:0] REGION_ENABLE = 3'h2;
    localparam logic [2:0] REGION_GWCTRL = 3'h3;
    localparam logic [2:0] REGION_GWCLR = 3'h4;

    // Word offsets inside the global region, bits [9:2]
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_THRESH = 8'h01;
    localparam logic [7:0] OFS_CURLVL = 8'h02;
    localparam logic [7:0] OFS_CLAIMPRI = 8'h03;
    localparam logic [7:0] OFS_VECBASE = 8'h04;
    localparam logic [7:0] OFS_CAPTURE = 8'h05;
    localparam logic [7:0] OFS_HANDLER = 8'h06;
    localparam logic [7:0] OFS_STATUS = 8'h07;

    // Field positions
    localparam int CFG_REV_BIT = 0;
    localparam int GW_POL_BIT = 0;
    localparam int GW_EDGE_BIT = 1;
    localparam int VECBASE_LSB = 10;
    localparam int STAT_NOTIFY_BIT = 31;
    localparam int STAT_WAKE_BIT = 30;
    localparam int STAT_ID_LSB = 8;

    // Values after reset and fixed levels
    localparam logic [PRI_W-1:0] PRI_RST = 4'h0;
    localparam logic [PRI_W-1:0] PRI_TOP = 4'hF;
    localparam logic [BASE_W-1:0] BASE_RST = 22'h000000;
    localparam logic [ID_W-1:0] ID_NONE = 8'h00;

    typedef struct packed {
        logic edge_mode;   // 1: edge, 0: level
        logic polarity;    // 1: falling / active low
    } gw_cfg_t;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic [PRI_W-1:0] pri;
    } win_t;

    localparam gw_cfg_t GW_CFG_RST = '{edge_mode: 1'b0, polarity: 1'b0};
endpackage : pic_pkg

// File: tb/src_model.sv
// Behavioural model of the interrupt sources on the far side of the controller.
// Assumes the bench asks for a level per source; the model enforces a minimum hold.
`timescale 1ns/10ps
module src_model #(
    parameter int N = 16
) (
    input wire logic core_clk,   // Controller clock
    input wire logic [N:1] drive, // Requested level per source
    output logic [N:1] ext_src   // Skewed source lines
);
    logic [N:1] line_r;
    logic [1:0] age_r [1:N];

    initial begin
        line_r = '0;
        for (int s = 1; s <= N; s++) age_r[s] = 2'h2;
    end

    // A request never changes before it has stood two full clocks
    always @(posedge core_clk) begin
        for (int s = 1; s <= N; s++) begin
            if (age_r[s] < 2'h2) begin
                age_r[s] <= age_r[s] + 2'h1;
            end else if (drive[s] !== line_r[s]) begin
                line_r[s] <= drive[s];
                age_r[s] <= 2'h0;
            end
        end
    end

    // Skew stands in for a source clock unrelated to the controller's
    assign #3 ext_src = line_r;
endmodule : src_model

// File: tb/testbench.sv
// Self-checking bench for the interrupt controller with a reduced source count.
// Assumes the register port and latencies described for the controller core.
`timescale 1ns/10ps
module testbench
    import pic_pkg::*;
;
    localparam int N = 16;
    logic core_clk, resetn, wr_en, rd_en, ext_int, wakeup, rev, nt, wk;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata, rd;
    logic [N:1] drive, ext_src, en_m;
    logic [ID_W-1:0] win_id, eid;
    logic [3:0] pri_m [1:N];
    logic [3:0] thr, cur, ep;
    logic [21:0] base;
    int num_errors, total_checks, dummy;

    pic_core #(.NUM_SRC(N), .NUM_CFG_GW(4)) dut (.core_clk(core_clk), .resetn(resetn),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .ext_src(ext_src), .ext_int(ext_int), .wakeup(wakeup), .win_id(win_id));
    src_model #(.N(N)) srcs (.core_clk(core_clk), .drive(drive), .ext_src(ext_src));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    function automatic logic [12:0] ra(input logic [2:0] reg_region, input logic [7:0] idx);
        return {reg_region, idx, 2'b00};
    endfunction : ra

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH reg t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH pin t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_pin

    task automatic reg_wr(input logic [12:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [12:0] a);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 rd = rdata;
    endtask : reg_rd

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc

    // Priority-type writes go through the firmware view of the ordering
    task automatic wr_pri(input logic [12:0] a, input logic [3:0] p);
        reg_wr(a, {28'h0, rev ? ~p : p});
    endtask : wr_pri

    // Strictly greater keeps the lowest ID on ties; priority zero never wins
    task automatic settle_check(input logic [N:1] act);
        eid = ID_NONE;
        ep = 4'h0;
        for (int s = 1; s <= N; s++)
            if (act[s] && en_m[s] && pri_m[s] > ep) begin
                eid = 8'(s);
                ep = pri_m[s];
            end
        nt = ep > thr && ep > cur;
        wk = ep == PRI_TOP;
        chk_pin(win_id, eid);
        chk_pin({7'h0, ext_int}, {7'h0, nt});
        chk_pin({7'h0, wakeup}, {7'h0, wk});
        reg_rd(ra(REGION_GLOBAL, OFS_STATUS));
        chk_reg(rd, {nt, wk, 14'h0, eid, 4'h0, rev ? ~ep : ep});
    endtask : settle_check

    task automatic set_src(input int s, input logic [3:0] p, input logic e);
        pri_m[s] = p;
        en_m[s] = e;
        wr_pri(ra(REGION_PRIO, 8'(s)), p);
        reg_wr(ra(REGION_ENABLE, 8'(s)), {31'h0, e});
    endtask : set_src

    initial begin
        #400000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        resetn = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = '0;
        wdata = '0;
        drive = '0;
        rev = 1'b0;
        en_m = '0;
        thr = 4'h0;
        cur = 4'h0;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        dummy = $urandom(19212);
        chk_pin({ext_int, wakeup, 6'h0}, 8'h00);
        // Reset values and refused places all read as zero
        for (int i = 0; i < 8; i++) begin
            reg_rd(ra(REGION_GLOBAL, 8'(i)));
            chk_reg(rd, 32'h0);
        end
        reg_rd(ra(REGION_GLOBAL, 8'h3F));
        chk_reg(rd, 32'h0);
        reg_rd(ra(REGION_PRIO, 8'h00));
        chk_reg(rd, 32'h0);
        reg_rd(ra(REGION_GWCTRL, 8'h01));
        chk_reg(rd, 32'h0);
        // Initialisation in the documented order
        base = 22'($urandom);
        reg_wr(ra(REGION_GLOBAL, OFS_CONFIG), 32'h0);
        reg_wr(ra(REGION_GWCLR, 8'h01), 32'h0);
        reg_wr(ra(REGION_GLOBAL, OFS_VECBASE), {base, 10'h0});
        for (int it = 0; it < 24; it++) begin
            for (int s = 1; s <= N; s++)
                pri_m[s] = it == 0 ? 4'h6 : it == 1 ? PRI_TOP : 4'($urandom % 16);
            for (int s = 1; s <= N; s++) wr_pri(ra(REGION_PRIO, 8'(s)), pri_m[s]);
            thr = it < 2 ? 4'h0 : 4'($urandom % 5);
            cur = it < 2 ? 4'h0 : 4'($urandom % 5);
            // No handler runs here, so the levels change while nothing is taken
            wr_pri(ra(REGION_GLOBAL, OFS_THRESH), thr);
            wr_pri(ra(REGION_GLOBAL, OFS_CURLVL), cur);
            wr_pri(ra(REGION_GLOBAL, OFS_CLAIMPRI), 4'h0);
            en_m = it < 2 ? '1 : N'($urandom);
            for (int s = 1; s <= N; s++) reg_wr(ra(REGION_ENABLE, 8'(s)), {31'h0, en_m[s]});
            drive <= it < 2 ? N'(16'hF0F0) : N'($urandom);
            wait_cyc(8);
            settle_check(drive);
            reg_wr(ra(REGION_GLOBAL, OFS_CAPTURE), 32'h0);
            reg_rd(ra(REGION_GLOBAL, OFS_HANDLER));
            chk_reg(rd, {base, eid, 2'b00});
            reg_rd(ra(REGION_GLOBAL, OFS_CLAIMPRI));
            chk_reg(rd, {28'h0, ep});
        end
        // Reversed ordering: firmware 0 is internally the top level
        drive <= N'(16'h0010);
        for (int s = 1; s <= N; s++) set_src(s, 4'h0, 1'b0);
        rev = 1'b1;
        reg_wr(ra(REGION_GLOBAL, OFS_CONFIG), 32'h1);
        thr = 4'h0;
        cur = 4'h0;
        wr_pri(ra(REGION_GLOBAL, OFS_THRESH), thr);
        wr_pri(ra(REGION_GLOBAL, OFS_CURLVL), cur);
        set_src(5, PRI_TOP, 1'b1);
        wait_cyc(4);
        settle_check(drive);
        reg_rd(ra(REGION_PRIO, 8'h05));
        chk_reg(rd, 32'h0);
        reg_rd(ra(REGION_GLOBAL, OFS_THRESH));
        chk_reg(rd, 32'hF);
        set_src(5, 4'h1, 1'b1);
        wait_cyc(4);
        settle_check(drive);
        set_src(5, 4'h0, 1'b0);
        rev = 1'b0;
        reg_wr(ra(REGION_GLOBAL, OFS_CONFIG), 32'h0);
        wr_pri(ra(REGION_GLOBAL, OFS_THRESH), thr);
        wr_pri(ra(REGION_GLOBAL, OFS_CURLVL), cur);
        // Rising-edge gateway on source 2 latches a short pulse
        drive <= '0;
        reg_wr(ra(REGION_GWCTRL, 8'h02), 32'h2);
        wait_cyc(8);
        reg_wr(ra(REGION_GWCLR, 8'h02), 32'h0);
        set_src(2, 4'h7, 1'b1);
        drive <= N'(16'h0002);
        wait_cyc(3);
        drive <= '0;
        wait_cyc(10);
        settle_check(N'(16'h0002));
        reg_rd(ra(REGION_GWCLR, 8'h02));
        chk_reg(rd, 32'h1);
        reg_wr(ra(REGION_GWCLR, 8'h02), 32'h0);
        wait_cyc(4);
        settle_check('0);
        // Active-low level gateway on source 3
        set_src(3, 4'h9, 1'b1);
        reg_wr(ra(REGION_GWCTRL, 8'h03), 32'h1);
        wait_cyc(6);
        settle_check(N'(16'h0004));
        drive <= N'(16'h0004);
        wait_cyc(8);
        settle_check('0);
        // Falling-edge gateway on source 4 latches the release of its line
        set_src(4, 4'h5, 1'b1);
        reg_wr(ra(REGION_GWCTRL, 8'h04), 32'h3);
        drive <= N'(16'h000C);
        wait_cyc(6);
        reg_wr(ra(REGION_GWCLR, 8'h04), 32'h0);
        settle_check(N'(16'h0000));
        drive <= N'(16'h0004);
        wait_cyc(8);
        settle_check(N'(16'h0008));
        tally_and_finish();
    end
endmodule : testbench
